/* hw/cce_exec.v */
// Purpose: execute call, byte/bit zero fill, watchdog clears and invert
// Assumes: decode strobe from fetch, data memory read combinational
// Notes: all outputs registered; one-cycle write/push/clear pulses
// Function
// - call pushes pc plus one, loads target, flags untouched
// - call takes two instruction cycles
// - zero fill writes whole byte to zero, no flag change
// - bit zero fill clears only selected bit, flags unchanged
// - single watchdog clear resets counter, expiry and sleep flags
// - pre-clears act only when the two alternate
// - invert stores ones complement, only zero flag updates
`timescale 1ns/10ps
`default_nettype none
`include "cce_map.vh"
module cce_exec (
	input wire clk,
	input wire rst,
	input wire instr_valid,
	input wire [2:0] instr_op,
	input wire [10:0] instr_target,
	input wire [7:0] instr_addr,
	input wire [2:0] instr_bit,
	input wire [7:0] mem_rdata,
	output reg busy,
	output reg [10:0] pc,
	output reg stack_push,
	output reg [10:0] stack_data,
	output reg mem_we,
	output reg [7:0] mem_addr,
	output reg [7:0] mem_wdata,
	output reg zero_flag,
	output reg watchdog_clear,
	output reg watchdog_expiry_flag,
	output reg sleep_entry_flag
);

	// call sequencing: idle takes requests, call2 is the extra cycle
	localparam ST_IDLE = 1'b0;
	localparam ST_CALL2 = 1'b1;

	// sequencer state and the call target held over the extra cycle
	reg state_q;
	reg state_d;
	reg [10:0] target_q;
	reg [10:0] target_d;

	// next values of the registered outputs
	reg busy_d;
	reg [10:0] pc_d;
	reg stack_push_d;
	reg [10:0] stack_data_d;
	reg mem_we_d;
	reg [7:0] mem_addr_d;
	reg [7:0] mem_wdata_d;
	reg zero_flag_d;
	reg watchdog_clear_d;
	reg watchdog_expiry_flag_d;
	reg sleep_entry_flag_d;

	// decode and datapath nets
	wire take;
	wire pre_fire;
	wire do_wdt;
	wire op_call;
	wire op_zero_fill;
	wire op_bit_zero_fill;
	wire op_wdt_single;
	wire op_wdt_pre1;
	wire op_wdt_pre2;
	wire op_invert;
	wire op_step;
	wire [7:0] bit_keep;
	wire [7:0] bit_cleared;
	wire [7:0] inverted;
	wire invert_zero;
	wire [10:0] pc_next;
	genvar g;

	// requests during the second call cycle are ignored; busy tells fetch
	assign take = instr_valid && state_q == ST_IDLE;

	// one decode line per opcode; nothing decodes while call2 holds
	assign op_call = take && instr_op == `CCE_OP_CALL;
	assign op_zero_fill = take && instr_op == `CCE_OP_ZERO_FILL;
	assign op_bit_zero_fill = take && instr_op == `CCE_OP_BIT_ZERO_FILL;
	assign op_wdt_single = take && instr_op == `CCE_OP_WDT_SINGLE;
	assign op_wdt_pre1 = take && instr_op == `CCE_OP_WDT_PRE1;
	assign op_wdt_pre2 = take && instr_op == `CCE_OP_WDT_PRE2;
	assign op_invert = take && instr_op == `CCE_OP_INVERT;

	// every single-cycle op moves to the next word; call and none do not
	assign op_step = op_zero_fill || op_bit_zero_fill || op_wdt_single ||
		op_wdt_pre1 || op_wdt_pre2 || op_invert;

	// the carry out of the top bit is dropped: the counter wraps
	assign pc_next = pc + `CCE_PC_STEP;

	// per-bit keep mask: only the selected position is forced low
	generate
		for (g = 0; g < `CCE_DATA_W; g = g + 1) begin : g_bit
			localparam [2:0] BIT_POS = g;
			assign bit_keep[g] = instr_bit != BIT_POS;
		end
	endgenerate

	// read-modify-write from the byte read in the taking cycle
	assign bit_cleared = mem_rdata & bit_keep;
	assign inverted = ~mem_rdata;

	// flag from the value stored, not the operand, so it tracks the write
	assign invert_zero = inverted == `CCE_ZERO_BYTE;

	// alternation memory for the two pre-clears lives in its own block
	cce_preclear u_pre (
		.clk(clk),
		.rst(rst),
		.pre_first(op_wdt_pre1),
		.pre_second(op_wdt_pre2),
		.fire(pre_fire)
	);

	// a lone pre-clear or a repeated one never reaches the counter
	assign do_wdt = op_wdt_single || pre_fire;

	// next state; pulses fall back to zero unless an op raises them
	always @* begin
		state_d = state_q;
		target_d = target_q;
		busy_d = 1'b0;
		pc_d = pc;
		stack_push_d = 1'b0;
		stack_data_d = stack_data;
		mem_we_d = 1'b0;
		mem_addr_d = mem_addr;
		mem_wdata_d = mem_wdata;
		zero_flag_d = zero_flag;
		watchdog_clear_d = 1'b0;
		watchdog_expiry_flag_d = watchdog_expiry_flag;
		sleep_entry_flag_d = sleep_entry_flag;
		case (state_q)
		ST_CALL2: begin
			// second cycle: the extra operation loads the target
			pc_d = target_q;
			state_d = ST_IDLE;
		end
		ST_IDLE: begin
			// the address is held so the memory sees it with the write
			if (take) begin
				mem_addr_d = instr_addr;
			end
			// call: push the return word, park the target for cycle two
			if (op_call) begin
				stack_push_d = 1'b1;
				stack_data_d = pc_next;
				target_d = instr_target;
				busy_d = 1'b1;
				state_d = ST_CALL2;
			end
			if (op_step) begin
				pc_d = pc_next;
			end
			// byte fill writes a constant; no flag is touched
			if (op_zero_fill) begin
				mem_we_d = 1'b1;
				mem_wdata_d = `CCE_ZERO_BYTE;
			end
			// bit fill keeps the neighbours from the read in this cycle
			if (op_bit_zero_fill) begin
				mem_we_d = 1'b1;
				mem_wdata_d = bit_cleared;
			end
			// invert is the only op here that moves the zero flag
			if (op_invert) begin
				mem_we_d = 1'b1;
				mem_wdata_d = inverted;
				zero_flag_d = invert_zero;
			end
			// counter and both status flags go together
			if (do_wdt) begin
				watchdog_clear_d = 1'b1;
				watchdog_expiry_flag_d = 1'b0;
				sleep_entry_flag_d = 1'b0;
			end
		end
		default: begin
			state_d = ST_IDLE;
		end
		endcase
	end

	// registers; every output comes straight from here
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_IDLE;
			target_q <= `CCE_PC_RESET;
			busy <= 1'b0;
			pc <= `CCE_PC_RESET;
			stack_push <= 1'b0;
			stack_data <= `CCE_PC_RESET;
			mem_we <= 1'b0;
			mem_addr <= `CCE_ZERO_BYTE;
			mem_wdata <= `CCE_ZERO_BYTE;
			zero_flag <= 1'b0;
			watchdog_clear <= 1'b0;
			watchdog_expiry_flag <= 1'b0;
			sleep_entry_flag <= 1'b0;
		end else begin
			state_q <= state_d;
			target_q <= target_d;
			busy <= busy_d;
			pc <= pc_d;
			stack_push <= stack_push_d;
			stack_data <= stack_data_d;
			mem_we <= mem_we_d;
			mem_addr <= mem_addr_d;
			mem_wdata <= mem_wdata_d;
			zero_flag <= zero_flag_d;
			watchdog_clear <= watchdog_clear_d;
			watchdog_expiry_flag <= watchdog_expiry_flag_d;
			sleep_entry_flag <= sleep_entry_flag_d;
		end
	end

	// limitation: the expiry and sleep flags are only ever cleared here;
	// whatever sets them lives with the watchdog and sleep logic, so a
	// wrapper that merges both must give this block's clear priority only
	// in the cycle after the instruction is taken.
	// trade-off: the read-modify-write ops trust mem_rdata in the taking
	// cycle, which keeps the path short but needs a combinational read.
endmodule // cce_exec
`default_nettype wire

/* hw/cce_preclear.v */
// Purpose: alternation tracker for the two watchdog pre-clear instructions
// Assumes: one strobe per executed instruction, same clock as the core
// Notes: fire pulses only when the other pre-clear was the last one seen
`timescale 1ns/10ps
`default_nettype none
`include "cce_map.vh"
module cce_preclear (
	input wire clk,
	input wire rst,
	input wire pre_first,
	input wire pre_second,
	output wire fire
);
	reg [1:0] last_q;
	reg [1:0] last_d;
	// a pre-clear takes effect only after the opposite one
	assign fire = (pre_first && last_q == `CCE_PRE_SECOND) ||
		(pre_second && last_q == `CCE_PRE_FIRST);
	// after reset neither counts as the last, so the first pair needs both
	always @* begin
		last_d = last_q;
		if (pre_first)
			last_d = `CCE_PRE_FIRST;
		else if (pre_second)
			last_d = `CCE_PRE_SECOND;
	end
	always @(posedge clk or posedge rst) begin
		if (rst)
			last_q <= `CCE_PRE_NONE;
		else
			last_q <= last_d;
	end
endmodule // cce_preclear
`default_nettype wire

/* pkg/cce_map.vh */
// Purpose: constants for the call/clear/complement execution slice
// Assumes: 8-bit data memory, 11-bit program counter
// Notes: opcode encodings on the decode port are local to this block
`ifndef CCE_MAP_VH
`define CCE_MAP_VH
`define CCE_OP_W 3
`define CCE_OP_NONE 3'h0
`define CCE_OP_CALL 3'h1
`define CCE_OP_ZERO_FILL 3'h2
`define CCE_OP_BIT_ZERO_FILL 3'h3
`define CCE_OP_WDT_SINGLE 3'h4
`define CCE_OP_WDT_PRE1 3'h5
`define CCE_OP_WDT_PRE2 3'h6
`define CCE_OP_INVERT 3'h7
`define CCE_PC_W 11
`define CCE_ADDR_W 8
`define CCE_DATA_W 8
`define CCE_ZERO_BYTE 8'h00
`define CCE_PC_RESET 11'h000
`define CCE_PC_STEP 11'h001
`define CCE_CALL_CYCLES 2'h2
`define CCE_PRE_NONE 2'h0
`define CCE_PRE_FIRST 2'h1
`define CCE_PRE_SECOND 2'h2
`endif

/* sim/call_clear_complement_exec_bench.sv */
// Purpose: random sweep of cce_exec
// Assumes: inputs move at the falling edge
// Notes: refused op rides in each call's busy cycle
`timescale 1ns/10ps
`default_nettype none
`include "cce_map.vh"
module call_clear_complement_exec_bench;
	logic clk = 0, rst = 1, instr_valid = 0, zx = 0;
	logic [2:0] instr_op = 0, instr_bit = 0, o;
	logic [1:0] lst = 0;
	logic [10:0] instr_target = 0, pm = 0;
	logic [2:0] seq [6] = '{3'h5, 3'h5, 3'h6, 3'h6, 3'h4, 3'h7};
	logic [7:0] instr_addr = 0, mem_rdata = 0;
	wire busy, stack_push, mem_we, zero_flag, watchdog_clear, watchdog_expiry_flag, sleep_entry_flag;
	wire [10:0] pc, stack_data;
	wire [7:0] mem_addr, mem_wdata;
	int bad_count = 0, checked = 0;
	always #12.5 clk = ~clk; // 40 MHz
	cce_exec i_dut (.*);
	// expected write data of the three memory ops
	function automatic logic [7:0] exp_wdata(input logic [2:0] op, input logic [7:0] d, input logic [2:0] b);
		if (op == `CCE_OP_ZERO_FILL) return 8'h00;
		if (op == `CCE_OP_BIT_ZERO_FILL) return d & ~(8'h01 << b);
		return ~d;
	endfunction
	task chk(input logic [19:0] g, e);
		checked++;
		if (g !== e) bad_count++;
		if (g !== e) $display("ERROR %0t got %h want %h", $time, g, e);
	endtask
	task complete_run;
		$display("checked %0d bad %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// one op every other cycle, every third after a call; all-ones data often, so the zero flag gets set
	initial begin
		mem_rdata = $urandom(38);
		repeat (6) @(negedge clk);
		rst = 0;
		for (int n = 0; n < 300; n++) begin
			@(negedge clk);
			o = n < 6 ? seq[n] : $urandom; // corner: repeated and alternated pre-clears first
			instr_valid = 1;
			instr_addr = $urandom;
			instr_op = o;
			instr_target = $urandom;
			instr_bit = $urandom;
			mem_rdata = $urandom % 3 ? $urandom : 8'hff;
			@(negedge clk);
			instr_valid = o == `CCE_OP_CALL;
			instr_op = `CCE_OP_INVERT;
			chk(watchdog_clear, o == `CCE_OP_WDT_SINGLE || o[2] && ^o[1:0] && lst != 0 && lst != o[1:0]);
			if (o[2] && ^o[1:0]) lst = o[1:0];
			if (o == `CCE_OP_INVERT) zx = mem_rdata == 8'hff;
			chk(zero_flag, zx);
			chk({watchdog_expiry_flag, sleep_entry_flag}, 0);
			if (o == 2 || o == 3 || o == 7)
				chk({mem_we, mem_addr, mem_wdata}, {1'b1, instr_addr, exp_wdata(o, mem_rdata, instr_bit)});
			else
				chk(mem_we, 0);
			if (o != `CCE_OP_CALL && o != 0) pm = pm + 11'h001;
			if (o != `CCE_OP_CALL) chk({busy, stack_push, pc}, {2'b00, pm});
			if (o == `CCE_OP_CALL) begin
				chk({busy, stack_push, stack_data}, {2'b11, pm + 11'h001});
				@(negedge clk);
				instr_valid = 0;
				pm = instr_target;
				chk({mem_we, busy, pc}, {2'b00, pm});
			end
		end
		$display("random sweep done");
		complete_run;
	end
endmodule // call_clear_complement_exec_bench
`default_nettype wire

/* sim/cce_exec_chk.sv */
// Purpose: port assertions for cce_exec
// Assumes: one clock, async reset
// Notes: keeps its own pre-clear memory
`timescale 1ns/10ps
`default_nettype none
`include "cce_map.vh"
module cce_chk (
	input wire logic clk, rst, instr_valid, busy, stack_push, mem_we, zero_flag, watchdog_clear,
	input wire logic watchdog_expiry_flag, sleep_entry_flag,
	input wire logic [2:0] instr_op, instr_bit,
	input wire logic [10:0] instr_target, pc, stack_data,
	input wire logic [7:0] instr_addr, mem_addr, mem_rdata, mem_wdata
);
	logic [1:0] last_q;
	// taken opcode, none while the call holds its second cycle
	wire [2:0] op = (instr_valid && !busy) ? instr_op : `CCE_OP_NONE;
	wire pre = op[2] && ^op[1:0];
	wire alt = last_q != `CCE_PRE_NONE && last_q != op[1:0];
	// reset forgets the last pre-clear, so the first one never fires
	always_ff @(posedge clk or posedge rst)
		if (rst) last_q <= `CCE_PRE_NONE;
		else if (pre) last_q <= op[1:0];
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_call_push: assert property (op == `CCE_OP_CALL |=> stack_push && stack_data == $past(pc) + 11'h001)
		else $error("call push");
	a_call_two: assert property (op == `CCE_OP_CALL |=> busy ##1 !busy && pc == $past(instr_target, 2))
		else $error("call load");
	a_flag_hold: assert property (op != `CCE_OP_INVERT |=> $stable(zero_flag)) else $error("flag");
	a_zero_fill: assert property (op == `CCE_OP_ZERO_FILL |=> mem_we && mem_wdata == 8'h00) else $error("fill");
	a_bit_clear: assert property (op == `CCE_OP_BIT_ZERO_FILL |=> mem_we &&
		mem_wdata == ($past(mem_rdata) & ~(8'h01 << $past(instr_bit)))) else $error("bit");
	a_wdt_single: assert property (op == `CCE_OP_WDT_SINGLE |=> watchdog_clear) else $error("wdt");
	a_pre_alt: assert property (pre |=> watchdog_clear == $past(alt)) else $error("pre");
	a_wdt_flags: assert property (watchdog_clear |-> !watchdog_expiry_flag && !sleep_entry_flag)
		else $error("wdt flags");
	a_mem_addr: assert property (op == `CCE_OP_ZERO_FILL || op == `CCE_OP_BIT_ZERO_FILL ||
		op == `CCE_OP_INVERT |=> mem_addr == $past(instr_addr)) else $error("addr");
	a_pc_step: assert property (op[2] || op[1] |=> pc == $past(pc) + 11'h001) else $error("step");
	a_invert_byte: assert property (op == `CCE_OP_INVERT |=> mem_we && mem_wdata == ~$past(mem_rdata) &&
		zero_flag == ($past(mem_rdata) == 8'hff)) else $error("invert");
endmodule // cce_chk
bind cce_exec cce_chk i_chk (.*);
`default_nettype wire
